// file: hdl/fwsc_cycle.sv
// Single bus cycle engine: one write or one read on the flash strobes
`timescale 1ns/100ps
module fwsc_cycle #(
  parameter int AW = 20
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] dq_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic dq_oe_n_out,
  output logic [AW-1:0] a_out,
  output logic [7:0] dq_out
);
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_SETUP = 2'b01,
    CY_PULSE = 2'b10,
    CY_HOLD = 2'b11
  } fwsc_cy_t;
  typedef struct packed {
    fwsc_cy_t st;
    logic [7:0] cnt;
    logic wr;
    logic done;
    logic [7:0] rdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [AW-1:0] a;
    logic [7:0] dq;
  } fwsc_cy_state_t;
  fwsc_cy_state_t s_r, s_nxt;

  // ---------------------------------------------------------------
  // Strobe sequencing
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      CY_IDLE: begin
        if (start_in) begin
          s_nxt.st = CY_SETUP;
          s_nxt.wr = write_in;
          s_nxt.a = addr_in;
          s_nxt.dq = data_in;
          s_nxt.dq_oe_n = ~write_in;
          s_nxt.ce_n = 1'b0;
          s_nxt.cnt = 8'(fwsc_pkg::SETUP_CYC);
        end
      end
      CY_SETUP: begin
        if (s_r.cnt <= 8'h01) begin
          s_nxt.st = CY_PULSE;
          s_nxt.cnt = 8'(fwsc_pkg::PULSE_CYC);
          // Falling read strobe latches status or array data in the device
          if (s_r.wr) s_nxt.we_n = 1'b0;
          else s_nxt.oe_n = 1'b0;
        end else s_nxt.cnt = s_r.cnt - 8'h01;
      end
      CY_PULSE: begin
        if (s_r.cnt <= 8'h01) begin
          s_nxt.st = CY_HOLD;
          s_nxt.cnt = 8'(fwsc_pkg::HOLD_CYC);
          s_nxt.rdata = dq_in;
          // Rising write strobe latches address and data
          s_nxt.we_n = 1'b1;
          s_nxt.oe_n = 1'b1;
        end else s_nxt.cnt = s_r.cnt - 8'h01;
      end
      CY_HOLD: begin
        if (s_r.cnt <= 8'h01) begin
          // Chip enable returns high between cycles
          s_nxt.st = CY_IDLE;
          s_nxt.ce_n = 1'b1;
          s_nxt.dq_oe_n = 1'b1;
          s_nxt.done = 1'b1;
        end else s_nxt.cnt = s_r.cnt - 8'h01;
      end
      default: s_nxt.st = CY_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s_r <= '{st: CY_IDLE, cnt: 8'h00, wr: 1'b0, done: 1'b0, rdata: 8'h00, ce_n: 1'b1,
               oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1, a: '0, dq: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_out = s_r.done;
  assign rdata_out = s_r.rdata;
  assign ce_n_out = s_r.ce_n;
  assign oe_n_out = s_r.oe_n;
  assign we_n_out = s_r.we_n;
  assign dq_oe_n_out = s_r.dq_oe_n;
  assign a_out = s_r.a;
  assign dq_out = s_r.dq;
endmodule : fwsc_cycle

// file: hdl/fwsc_host.sv
// Host controller that issues erase, write, suspend and status sequences to a byte-wide flash
`timescale 1ns/100ps
module fwsc_host #(
  parameter int AW = 20
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic OP_VALID_IN,
  input wire logic [2:0] OP_CODE_IN,
  input wire logic [AW-1:0] OP_ADDR_IN,
  input wire logic [7:0] OP_DATA_IN,
  output logic OP_READY_OUT,
  output logic OP_DONE_OUT,
  output logic [7:0] OP_RDATA_OUT,
  output logic [7:0] STATUS_OUT,
  output logic OP_ERROR_OUT,
  output logic OP_REFUSED_OUT,
  input wire logic READY_BUSY_N_IN,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_N_OUT,
  output logic [AW-1:0] A_OUT,
  output logic CE_N_OUT,
  output logic OE_N_OUT,
  output logic WE_N_OUT
);
  // Refuse address widths the bus cycle engine cannot serve
  if (AW < 1 || AW > 32) begin : g_aw_check
    $error("fwsc_host: AW out of range");
  end

  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0000,
    HS_CMD1 = 4'b0001,
    HS_CMD2 = 4'b0010,
    HS_POLL = 4'b0011,
    HS_CHECK = 4'b0100,
    HS_FINISH = 4'b0101
  } fwsc_hs_t;
  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00,
    MD_ERASE_SUSP = 2'b01,
    MD_WRITE_SUSP = 2'b10
  } fwsc_md_t;
  typedef struct packed {
    fwsc_hs_t st;
    fwsc_md_t md;
    logic [2:0] op;
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic busy_alg;
    logic go;
    logic gowr;
    logic [AW-1:0] ga;
    logic [7:0] gd;
    logic ready;
    logic done;
    logic [7:0] rdata;
    logic [7:0] status;
    logic err;
    logic refused;
  } fwsc_host_state_t;
  fwsc_host_state_t s_r, s_nxt;

  logic cy_done;
  logic [7:0] cy_rdata;

  // Error flags relevant to the operation just finished
  function automatic logic op_failed(input logic [2:0] op, input logic [7:0] sr);
    if (op == 3'(fwsc_pkg::OP_ERASE)) return sr[fwsc_pkg::SR_ERASE_ERR] |
      sr[fwsc_pkg::SR_VPP_LOW] | sr[fwsc_pkg::SR_LOCK_ERR];
    else if (op == 3'(fwsc_pkg::OP_WRITE)) return sr[fwsc_pkg::SR_WRITE_ERR] |
      sr[fwsc_pkg::SR_VPP_LOW] | sr[fwsc_pkg::SR_LOCK_ERR];
    else return 1'b0;
  endfunction : op_failed

  // Whether an operation is legal in the present mode
  function automatic logic op_allowed(input logic [2:0] op, input fwsc_md_t md,
                                      input logic busy);
    logic ok;
    ok = 1'b1;
    if (md == MD_ERASE_SUSP) begin
      ok = (op != 3'(fwsc_pkg::OP_ERASE)) && (op != 3'(fwsc_pkg::OP_SUSPEND) || busy) &&
           (op != 3'(fwsc_pkg::OP_CLEAR_STATUS));
    end else if (md == MD_WRITE_SUSP) begin
      ok = (op == 3'(fwsc_pkg::OP_READ_STATUS)) || (op == 3'(fwsc_pkg::OP_RESUME)) ||
           (op == 3'(fwsc_pkg::OP_READ_ARRAY)) || (op == 3'(fwsc_pkg::OP_READ));
    end else begin
      ok = (op != 3'(fwsc_pkg::OP_RESUME)) && (op != 3'(fwsc_pkg::OP_SUSPEND) || busy);
      if (busy && op == 3'(fwsc_pkg::OP_READ_ARRAY)) ok = 1'b0;
    end
    return ok;
  endfunction : op_allowed

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.done = 1'b0;
    s_nxt.refused = 1'b0;
    case (s_r.st)
      HS_IDLE: begin
        s_nxt.ready = 1'b1;
        if (OP_VALID_IN && s_r.ready) begin
          s_nxt.ready = 1'b0;
          s_nxt.op = OP_CODE_IN;
          s_nxt.addr = OP_ADDR_IN;
          s_nxt.data = OP_DATA_IN;
          s_nxt.err = 1'b0;
          if (!op_allowed(OP_CODE_IN, s_r.md, s_r.busy_alg)) begin
            // Undefined or illegal sequences never reach the pins
            s_nxt.refused = 1'b1;
            s_nxt.done = 1'b1;
            s_nxt.st = HS_FINISH;
          end else begin
            s_nxt.go = 1'b1;
            s_nxt.gowr = 1'b1;
            s_nxt.ga = OP_ADDR_IN;
            s_nxt.st = HS_CMD1;
            case (OP_CODE_IN)
              3'(fwsc_pkg::OP_READ_STATUS): s_nxt.gd = fwsc_pkg::CMD_READ_STATUS;
              3'(fwsc_pkg::OP_CLEAR_STATUS): s_nxt.gd = fwsc_pkg::CMD_CLEAR_STATUS;
              3'(fwsc_pkg::OP_ERASE): s_nxt.gd = fwsc_pkg::CMD_ERASE_SETUP;
              3'(fwsc_pkg::OP_WRITE): s_nxt.gd = fwsc_pkg::CMD_WRITE_SETUP;
              3'(fwsc_pkg::OP_SUSPEND): s_nxt.gd = fwsc_pkg::CMD_SUSPEND;
              3'(fwsc_pkg::OP_RESUME): s_nxt.gd = fwsc_pkg::CMD_CONFIRM;
              3'(fwsc_pkg::OP_READ_ARRAY): s_nxt.gd = fwsc_pkg::CMD_READ_ARRAY;
              default: begin
                // Plain read of whatever mode the device is in
                s_nxt.gowr = 1'b0;
                s_nxt.gd = 8'h00;
              end
            endcase
          end
        end
      end
      HS_CMD1: begin
        if (cy_done) begin
          s_nxt.rdata = cy_rdata;
          if (s_r.op == 3'(fwsc_pkg::OP_ERASE) || s_r.op == 3'(fwsc_pkg::OP_WRITE)) begin
            // Second cycle: confirm in block, or address and data
            s_nxt.go = 1'b1;
            s_nxt.gowr = 1'b1;
            s_nxt.ga = s_r.addr;
            s_nxt.gd = (s_r.op == 3'(fwsc_pkg::OP_ERASE)) ? fwsc_pkg::CMD_CONFIRM : s_r.data;
            s_nxt.st = HS_CMD2;
          end else if (s_r.op == 3'(fwsc_pkg::OP_READ)) begin
            s_nxt.done = 1'b1;
            s_nxt.st = HS_FINISH;
          end else if (s_r.op == 3'(fwsc_pkg::OP_SUSPEND) ||
                       s_r.op == 3'(fwsc_pkg::OP_RESUME)) begin
            s_nxt.st = HS_POLL;
          end else begin
            if (s_r.op == 3'(fwsc_pkg::OP_READ_ARRAY) && s_r.md == MD_WRITE_SUSP) begin
              s_nxt.md = MD_WRITE_SUSP;
            end
            s_nxt.done = 1'b1;
            s_nxt.st = HS_FINISH;
          end
        end
      end
      HS_CMD2: begin
        if (cy_done) begin
          s_nxt.busy_alg = 1'b1;
          s_nxt.st = HS_POLL;
        end
      end
      HS_POLL: begin
        // Suspend is the one request taken while an erase or write runs
        if (OP_VALID_IN && OP_CODE_IN == 3'(fwsc_pkg::OP_SUSPEND) &&
            (s_r.op == 3'(fwsc_pkg::OP_ERASE) || s_r.op == 3'(fwsc_pkg::OP_WRITE))) begin
          s_nxt.op = OP_CODE_IN;
          s_nxt.go = 1'b1;
          s_nxt.gowr = 1'b1;
          s_nxt.gd = fwsc_pkg::CMD_SUSPEND;
          s_nxt.st = HS_CMD1;
        end else if (READY_BUSY_N_IN) begin
          // Device no longer busy: read status
          s_nxt.go = 1'b1;
          s_nxt.gowr = 1'b0;
          s_nxt.st = HS_CHECK;
        end
      end
      HS_CHECK: begin
        if (cy_done) begin
          // Device answers status after erase, write, suspend and resume sequences
          s_nxt.status = cy_rdata;
          s_nxt.rdata = cy_rdata;
          if (!cy_rdata[fwsc_pkg::SR_READY]) begin
            s_nxt.st = HS_POLL;
          end else begin
            s_nxt.err = op_failed(s_r.op, cy_rdata);
            s_nxt.done = 1'b1;
            s_nxt.st = HS_FINISH;
            if (cy_rdata[fwsc_pkg::SR_WRITE_SUSP]) begin
              s_nxt.md = MD_WRITE_SUSP;
            end else if (cy_rdata[fwsc_pkg::SR_ERASE_SUSP]) begin
              s_nxt.md = MD_ERASE_SUSP;
            end else begin
              s_nxt.md = MD_NORMAL;
            end
            // An erase resumed only after nested writes have ended
            s_nxt.busy_alg = 1'b0;
          end
        end
      end
      HS_FINISH: begin
        s_nxt.st = HS_IDLE;
        s_nxt.ready = 1'b1;
      end
      default: s_nxt.st = HS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s_r <= '{st: HS_IDLE, md: MD_NORMAL, op: 3'h0, addr: '0, data: 8'h00, busy_alg: 1'b0,
               go: 1'b0, gowr: 1'b0, ga: '0, gd: 8'h00, ready: 1'b0, done: 1'b0,
               rdata: 8'h00, status: 8'h00, err: 1'b0, refused: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle engine
  // ---------------------------------------------------------------
  fwsc_cycle #(.AW(AW)) u_cycle (
    .CLK_IN(CLK_IN),
    .RST_IN(RST_IN),
    .start_in(s_r.go),
    .write_in(s_r.gowr),
    .addr_in(s_r.ga),
    .data_in(s_r.gd),
    .dq_in(DQ_IN),
    .done_out(cy_done),
    .rdata_out(cy_rdata),
    .ce_n_out(CE_N_OUT),
    .oe_n_out(OE_N_OUT),
    .we_n_out(WE_N_OUT),
    .dq_oe_n_out(DQ_OE_N_OUT),
    .a_out(A_OUT),
    .dq_out(DQ_OUT)
  );

  assign OP_READY_OUT = s_r.ready;
  assign OP_DONE_OUT = s_r.done;
  assign OP_RDATA_OUT = s_r.rdata;
  assign STATUS_OUT = s_r.status;
  assign OP_ERROR_OUT = s_r.err;
  assign OP_REFUSED_OUT = s_r.refused;
endmodule : fwsc_host

// file: hdl/fwsc_pkg.sv
// Package of command codes, status bit positions and strobe timing for the flash host controller
package fwsc_pkg;
  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  // ---------------------------------------------------------------
  // Status bit positions
  // ---------------------------------------------------------------
  localparam int SR_READY = 7;
  localparam int SR_ERASE_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_WRITE_ERR = 4;
  localparam int SR_VPP_LOW = 3;
  localparam int SR_WRITE_SUSP = 2;
  localparam int SR_LOCK_ERR = 1;
  // ---------------------------------------------------------------
  // Strobe timing: phase lengths in ns and clock periods
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SETUP_NS = 40;
  localparam int PULSE_NS = 100;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // User operation codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ_STATUS = 3'b000,
    OP_CLEAR_STATUS = 3'b001,
    OP_ERASE = 3'b010,
    OP_WRITE = 3'b011,
    OP_SUSPEND = 3'b100,
    OP_RESUME = 3'b101,
    OP_READ_ARRAY = 3'b110,
    OP_READ = 3'b111
  } fwsc_op_t;
endpackage : fwsc_pkg

// file: test/fwsc_flash_model.sv
// Behavioural byte-wide flash device answering the host strobes
`timescale 1ns/100ps
module fwsc_flash_model (
  input wire logic clk_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [19:0] a_in,
  input wire logic [7:0] dq_in,
  input wire logic vpp_low_in,
  input wire logic lock_in,
  output logic [7:0] dq_out,
  output logic ready_busy_n_out
);
  logic [7:0] mem_r [16];
  logic [3:0] err_r = 4'h0; // Erase, write, supply, lock
  logic [7:0] rd_r = 8'h00;
  logic [1:0] setup_r = 2'h0;
  logic stat_r = 1'b0;
  logic esusp_r = 1'b0;
  logic wsusp_r = 1'b0;
  logic we_q = 1'b1;
  logic oe_q = 1'b1;
  int ecnt = 0;
  int wcnt = 0;
  logic busy;
  logic [7:0] status;
  // Busy, status byte and bus output
  assign busy = (ecnt > 0 && !esusp_r) || (wcnt > 0 && !wsusp_r);
  assign ready_busy_n_out = !busy;
  assign status = {!busy, esusp_r, err_r[3:1], wsusp_r, err_r[0], 1'b0};
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_r : ~rd_r; // Released bus shows inverse
  initial foreach (mem_r[i]) mem_r[i] = 8'hff; // Blank flash reads all ones
  // Algorithm timers, read latch and command decode
  always @(posedge clk_in) begin
    we_q <= we_n_in;
    oe_q <= oe_n_in;
    if (wcnt > 0 && !wsusp_r) wcnt <= wcnt - 1;
    else if (ecnt > 0 && !esusp_r) ecnt <= ecnt - 1;
    if (oe_q && !oe_n_in && !ce_n_in) rd_r <= stat_r ? status : mem_r[a_in[3:0]];
    if (!we_q && we_n_in && !ce_n_in) begin
      if (setup_r == 2'h1) begin
        setup_r <= 2'h0;
        stat_r <= 1'b1;
        if (dq_in != 8'hd0) err_r <= err_r | 4'hc;
        else if (vpp_low_in) err_r <= err_r | 4'ha;
        else if (lock_in) err_r <= err_r | 4'h9;
        else begin
          foreach (mem_r[i]) mem_r[i] <= 8'hff;
          ecnt <= 40;
        end
      end else if (setup_r == 2'h2) begin
        setup_r <= 2'h0;
        stat_r <= 1'b1;
        if (vpp_low_in) err_r <= err_r | 4'h6;
        else if (lock_in) err_r <= err_r | 4'h5;
        else begin
          mem_r[a_in[3:0]] <= mem_r[a_in[3:0]] & dq_in;
          wcnt <= 20;
        end
      end else begin
        case (dq_in)
          8'h70: stat_r <= 1'b1;
          8'h50: if (!esusp_r && !wsusp_r) err_r <= 4'h0;
          8'hff: if (!busy) stat_r <= 1'b0;
          8'h20: setup_r <= 2'h1;
          8'h40, 8'h10: setup_r <= 2'h2;
          8'hb0: begin
            stat_r <= 1'b1;
            if (wcnt > 0 && !wsusp_r) wsusp_r <= 1'b1;
            else if (ecnt > 0) esusp_r <= 1'b1;
          end
          8'hd0: begin
            stat_r <= 1'b1;
            if (wsusp_r) wsusp_r <= 1'b0;
            else esusp_r <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : fwsc_flash_model

// file: test/fwsc_props.sv
// Checker of the flash host controller strobe and handshake timing
`timescale 1ns/100ps
module fwsc_props (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic OP_VALID_IN,
  input wire logic OP_READY_OUT,
  input wire logic OP_DONE_OUT,
  input wire logic OP_REFUSED_OUT,
  input wire logic DQ_OE_N_OUT,
  input wire logic CE_N_OUT,
  input wire logic OE_N_OUT,
  input wire logic WE_N_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // Strobe shape and handshake relations
  AST_RESET_IDLE: assert property ($fell(RST_IN) |-> CE_N_OUT && OE_N_OUT && WE_N_OUT
    && DQ_OE_N_OUT && !OP_READY_OUT) else $error("bus not idle after reset");
  AST_WE_PULSE: assert property ($fell(WE_N_OUT) |-> !WE_N_OUT [*5] ##1 WE_N_OUT)
    else $error("write strobe width wrong");
  AST_WE_QUAL: assert property (!WE_N_OUT |-> !CE_N_OUT && !DQ_OE_N_OUT && OE_N_OUT)
    else $error("write strobe without select or data");
  AST_WE_HOLD: assert property ($rose(WE_N_OUT) |-> ##2 $rose(CE_N_OUT) && $rose(DQ_OE_N_OUT))
    else $error("data not held past write strobe");
  AST_OE_PULSE: assert property ($fell(OE_N_OUT) |-> !OE_N_OUT [*5] ##1 OE_N_OUT)
    else $error("read strobe width wrong");
  AST_OE_TOGGLE: assert property ($rose(OE_N_OUT) |-> OE_N_OUT [*3])
    else $error("read strobe not returned high");
  AST_DONE_PULSE: assert property ($rose(OP_DONE_OUT) |=> !OP_DONE_OUT)
    else $error("done longer than one cycle");
  AST_REFUSED_DONE: assert property (OP_REFUSED_OUT |-> OP_DONE_OUT)
    else $error("refusal without done");
  AST_TAKE_DROP: assert property (OP_VALID_IN && OP_READY_OUT |=> !OP_READY_OUT)
    else $error("ready kept after take");
  AST_IDLE_NO_CE: assert property (OP_READY_OUT |-> CE_N_OUT)
    else $error("bus cycle while idle");
endmodule : fwsc_props

bind fwsc_host fwsc_props u_fwsc_props (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .OP_VALID_IN(OP_VALID_IN), .OP_READY_OUT(OP_READY_OUT),
  .OP_DONE_OUT(OP_DONE_OUT), .OP_REFUSED_OUT(OP_REFUSED_OUT), .DQ_OE_N_OUT(DQ_OE_N_OUT),
  .CE_N_OUT(CE_N_OUT), .OE_N_OUT(OE_N_OUT), .WE_N_OUT(WE_N_OUT)
);

// file: test/test_fwsc_host.sv
// Self-checking bench of the flash host controller against a device model
`timescale 1ns/100ps
module test_fwsc_host;
  logic clk;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [19:0] op_addr = 20'h00000;
  logic [7:0] op_data = 8'h00;
  logic vpp_low = 1'b0;
  logic lock = 1'b0;
  logic op_ready, op_done, op_error, op_refused, dq_oe_n, ce_n, oe_n, we_n, rb_n, er, rf;
  logic [7:0] op_rdata, host_dq, dev_dq, dq_bus, rd, status_seen;
  logic [19:0] a;
  int errors = 0;
  int check_count = 0;
  // Bus level from whichever side drives
  assign dq_bus = (dq_oe_n === 1'b0) ? host_dq : dev_dq;
  fwsc_host u_fwsc_host (
    .CLK_IN(clk), .RST_IN(rst), .OP_VALID_IN(op_valid), .OP_CODE_IN(op_code),
    .OP_ADDR_IN(op_addr), .OP_DATA_IN(op_data), .OP_READY_OUT(op_ready), .OP_DONE_OUT(op_done),
    .OP_RDATA_OUT(op_rdata), .STATUS_OUT(status_seen), .OP_ERROR_OUT(op_error),
    .OP_REFUSED_OUT(op_refused), .READY_BUSY_N_IN(rb_n), .DQ_IN(dq_bus), .DQ_OUT(host_dq),
    .DQ_OE_N_OUT(dq_oe_n), .A_OUT(a), .CE_N_OUT(ce_n), .OE_N_OUT(oe_n), .WE_N_OUT(we_n)
  );
  fwsc_flash_model u_fwsc_flash_model (
    .clk_in(clk), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .a_in(a), .dq_in(dq_bus),
    .vpp_low_in(vpp_low), .lock_in(lock), .dq_out(dev_dq), .ready_busy_n_out(rb_n)
  );
  // Compare one value and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One user request, held until taken, then wait for done
  task automatic do_op(input logic [2:0] code, input logic [19:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    do @(posedge clk); while (op_ready !== 1'b1 && n++ < 3000);
    op_valid <= 1'b1;
    op_code <= code;
    op_addr <= addr;
    op_data <= data;
    @(posedge clk);
    op_valid <= 1'b0;
    do @(posedge clk); while (op_done !== 1'b1 && n++ < 3000);
    rd = op_rdata;
    er = op_error;
    rf = op_refused;
    if (n > 3000) errors++;
  endtask : do_op
  // Start an erase or write, then ask for suspend once the device reports busy
  task automatic op_suspend(input logic [2:0] code, input logic [19:0] addr,
                            input logic [7:0] data);
    int n;
    n = 0;
    do @(posedge clk); while (op_ready !== 1'b1 && n++ < 3000);
    op_valid <= 1'b1;
    op_code <= code;
    op_addr <= addr;
    op_data <= data;
    @(posedge clk);
    op_valid <= 1'b0;
    do @(posedge clk); while (rb_n !== 1'b0 && n++ < 3000);
    op_valid <= 1'b1;
    op_code <= fwsc_pkg::OP_SUSPEND;
    do @(posedge clk); while (op_done !== 1'b1 && n++ < 3000);
    op_valid <= 1'b0;
    rd = op_rdata;
    er = op_error;
    rf = op_refused;
    if (n > 3000) errors++;
  endtask : op_suspend
  task automatic t_status();
    do_op(fwsc_pkg::OP_READ_STATUS, 20'h00000, 8'h00);
    check("refused", {7'h0, rf}, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00000, 8'h00);
    check("status", rd, 8'h80);
  endtask : t_status
  task automatic t_write_erase();
    do_op(fwsc_pkg::OP_WRITE, 20'h00005, 8'h3c);
    check("write error", {7'h0, er}, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00005, 8'h00);
    check("status after write", rd, 8'h80);
    do_op(fwsc_pkg::OP_WRITE, 20'h00005, 8'hf0);
    do_op(fwsc_pkg::OP_READ_ARRAY, 20'h00000, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00005, 8'h00);
    check("byte", rd, 8'h30);
    do_op(fwsc_pkg::OP_ERASE, 20'h00005, 8'h00);
    check("erase error", {7'h0, er}, 8'h00);
    do_op(fwsc_pkg::OP_READ_ARRAY, 20'h00000, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00009, 8'h00);
    check("erased", rd, 8'hff);
  endtask : t_write_erase
  task automatic t_faults(input logic v, input logic [7:0] es, input logic [7:0] ws);
    vpp_low <= v;
    lock <= !v;
    do_op(fwsc_pkg::OP_ERASE, 20'h00002, 8'h00);
    check("erase fault", rd, es);
    check("erase flag", {7'h0, er}, 8'h01);
    do_op(fwsc_pkg::OP_WRITE, 20'h00003, 8'h00);
    check("write fault", rd, ws);
    check("status out", status_seen, ws);
    do_op(fwsc_pkg::OP_CLEAR_STATUS, 20'h00000, 8'h00);
    do_op(fwsc_pkg::OP_READ_STATUS, 20'h00000, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00000, 8'h00);
    check("cleared", rd, 8'h80);
    vpp_low <= 1'b0;
    lock <= 1'b0;
  endtask : t_faults
  task automatic t_refuse();
    do_op(fwsc_pkg::OP_RESUME, 20'h00000, 8'h00);
    check("resume refused", {7'h0, rf}, 8'h01);
    do_op(fwsc_pkg::OP_SUSPEND, 20'h00000, 8'h00);
    check("suspend refused", {7'h0, rf}, 8'h01);
  endtask : t_refuse
  task automatic t_suspend();
    op_suspend(fwsc_pkg::OP_ERASE, 20'h00000, 8'h00);
    check("erase suspended", rd, 8'hc0);
    check("busy pin", {7'h0, rb_n}, 8'h01);
    do_op(fwsc_pkg::OP_CLEAR_STATUS, 20'h00000, 8'h00);
    check("clear in suspend", {7'h0, rf}, 8'h01);
    do_op(fwsc_pkg::OP_WRITE, 20'h00007, 8'h5a);
    check("nested write", rd, 8'hc0);
    do_op(fwsc_pkg::OP_RESUME, 20'h00000, 8'h00);
    check("erase resumed", rd, 8'h80);
    op_suspend(fwsc_pkg::OP_WRITE, 20'h00008, 8'h0f);
    check("write suspended", rd, 8'h84);
    check("write suspend error", {7'h0, er}, 8'h00);
    do_op(fwsc_pkg::OP_ERASE, 20'h00000, 8'h00);
    check("erase in write suspend", {7'h0, rf}, 8'h01);
    do_op(fwsc_pkg::OP_RESUME, 20'h00000, 8'h00);
    check("write resumed", rd, 8'h80);
    do_op(fwsc_pkg::OP_READ_ARRAY, 20'h00000, 8'h00);
    do_op(fwsc_pkg::OP_READ, 20'h00007, 8'h00);
    check("nested byte", rd, 8'h5a);
    do_op(fwsc_pkg::OP_READ, 20'h00008, 8'h00);
    check("resumed byte", rd, 8'h0f);
  endtask : t_suspend
  task automatic print_verdict();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // Clock, main sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_status();
    t_write_erase();
    t_faults(1'b1, 8'ha8, 8'hb8);
    t_faults(1'b0, 8'ha2, 8'hb2);
    t_refuse();
    t_suspend();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule : test_fwsc_host
